// ===== src/ide_task_regs.sv
// Task-file register set of the card in IDE mode, with its sector data buffers.
//
// What this block does
// - CE1 low decodes eight task-file registers
// - CE2 low: alt status/control, drive address
// - 16-bit data port, word or byte access
// - Data port overlaps error/feature offset
// - Error byte read-only, valid when not busy
// - Bit 7 bad block; bits 5,3,1 zero
// - Bit 6 uncorrectable read data error
// - Bit 4 sector identifier not found
// - Bit 2 command aborted by card condition
// - Bit 0 general error
// - Feature byte write-only, passed to commands
// - Sector count zero means 256 sectors
// - Failed transfer leaves remaining sectors count
// - Sector count resets to 01h
// - Sector number holds starting sector
// - Cylinder low/high bytes hold start cylinder
// - Drive/head bits 7,5 one; LBA, drive
// - LBA flag picks CHS or linear addressing
// - Linear address built from four bytes
// - Drive bit compared against card identity
// - Bits 3..0 head number, bit 3 MSB
// - Busy hides other status bits
`timescale 1ns/1ps

// ----------------------------------------
// Parameterised FIFO
// ----------------------------------------
module sector_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk, // 200 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [W-1:0] in_data, // Word to store
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    output logic [W-1:0] out_data, // Oldest word
    output logic out_valid, // A word is held
    input wire logic out_ready // Oldest word taken
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (cnt_r != FULL_CNT);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and storage next state
    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = (wp_r == LAST_IDX) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == LAST_IDX) ? '0 : rp_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Control state is reset, storage is not
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage array
    always_ff @(posedge ref_clk) begin
        mem_r <= mem_nxt;
    end
endmodule

// ----------------------------------------
// Task-file register block
// ----------------------------------------
module ide_task_regs
    import ide_task_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk, // 200 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic cs1_n, // Task-file chip select
    input wire logic cs2_n, // Control-block chip select
    input wire logic [2:0] addr, // Register offset
    input wire logic rd_n, // Read strobe
    input wire logic wr_n, // Write strobe
    input wire logic word_mode, // High for 16-bit access
    input wire logic [DATA_W-1:0] host_din, // Host write data
    output logic [DATA_W-1:0] host_dout, // Host read data
    output logic host_doe, // Drive data bus
    output logic wr_space, // Write buffer has room
    output logic rd_avail, // Read buffer holds data
    input wire logic card_id, // This card's drive number
    input wire logic busy_flag, // Internal operation running
    input wire logic [6:0] status_low, // Status bits 6..0
    input wire logic err_set_valid, // Report error bits
    input wire logic [7:0] err_set_bits, // Error bits to set
    input wire logic cnt_upd_valid, // Load remaining count
    input wire logic [7:0] cnt_upd_value, // Remaining sectors
    output logic cmd_valid, // New command pulse
    output logic [7:0] cmd_code, // Command byte
    output logic [7:0] feature_byte, // Feature selection
    output logic [8:0] xfer_sectors, // Sectors, 1..256
    output logic lba_mode, // Linear addressing chosen
    output logic [27:0] lba_addr, // Linear block address
    output logic [15:0] cylinder, // Start cylinder
    output logic [3:0] head_field, // Head number
    output logic [7:0] start_sec, // Start sector
    output logic drive_select_bit, // Drive addressed
    output logic drive_match, // Addressed drive is us
    output logic soft_reset, // Soft reset level
    output logic irq_disable, // Interrupt disable level
    output logic [DATA_W-1:0] wdata, // Sector word to card
    output logic wvalid, // Sector word present
    input wire logic wready, // Card takes the word
    input wire logic [DATA_W-1:0] rdata_in, // Sector word from card
    input wire logic rvalid_in, // Card offers a word
    output logic rready_in // Read buffer has room
);
    // ----------------------------------------
    // Strobe edges and address decode
    // ----------------------------------------
    logic rd_prev_r, wr_prev_r;
    logic rd_go, wr_go, sel_task, sel_ctl;
    logic data_hit_rd, data_hit_wr;

    assign sel_task = !cs1_n && cs2_n;
    assign sel_ctl = cs1_n && !cs2_n && (addr[2:1] == OFS_ALT_CTL[2:1]);
    assign rd_go = !rd_n && rd_prev_r && (sel_task || sel_ctl);
    assign wr_go = !wr_n && wr_prev_r && (sel_task || sel_ctl);
    // A word access at offset 0 covers offset 1 too; byte accesses split them
    assign data_hit_rd = rd_go && sel_task && (addr == OFS_DATA);
    assign data_hit_wr = wr_go && sel_task && (addr == OFS_DATA);
    // Only the low-going edge of a strobe acts, so a long strobe counts once
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rd_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
        end else begin
            rd_prev_r <= rd_n;
            wr_prev_r <= wr_n;
        end
    end

    // ----------------------------------------
    // Parameter registers
    // ----------------------------------------
    logic [7:0] feat_r, feat_nxt, cnt_r, cnt_nxt, sec_r, sec_nxt;
    logic [7:0] cyl_lo_r, cyl_lo_nxt, cyl_hi_r, cyl_hi_nxt;
    logic [7:0] dh_r, dh_nxt, ctl_r, ctl_nxt, err_r, err_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic cmd_go_r, cmd_go_nxt, cmd_take;

    // New command only when idle and addressed to this card
    assign cmd_take = wr_go && sel_task && (addr == OFS_STAT_CMD) && !busy_flag && drive_match;

    // Host writes and card-side updates
    always_comb begin
        feat_nxt = feat_r;
        cnt_nxt = cnt_r;
        sec_nxt = sec_r;
        cyl_lo_nxt = cyl_lo_r;
        cyl_hi_nxt = cyl_hi_r;
        dh_nxt = dh_r;
        ctl_nxt = ctl_r;
        cmd_nxt = cmd_r;
        cmd_go_nxt = 1'b0;
        err_nxt = err_r;
        // Card reports the remainder of an unfinished transfer
        if (cnt_upd_valid) begin
            cnt_nxt = cnt_upd_value;
        end
        if (wr_go && sel_task) begin
            unique case (addr)
                OFS_ERR_FEAT: begin
                    if (!word_mode) begin
                        feat_nxt = host_din[7:0];
                    end
                end
                OFS_COUNT: cnt_nxt = host_din[7:0];
                OFS_SECTOR: sec_nxt = host_din[7:0];
                OFS_CYL_LO: cyl_lo_nxt = host_din[7:0];
                OFS_CYL_HI: cyl_hi_nxt = host_din[7:0];
                OFS_DRV_HEAD: dh_nxt = host_din[7:0] | DH_FIXED_ONES;
                OFS_STAT_CMD: begin
                    if (cmd_take) begin
                        cmd_nxt = host_din[7:0];
                        cmd_go_nxt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Drive address is read-only; writes there are dropped
        if (wr_go && sel_ctl && (addr == OFS_ALT_CTL)) begin
            ctl_nxt = host_din[7:0];
        end
        // A new command clears old errors; a report in the same cycle wins
        if (cmd_take) begin
            err_nxt = BYTE_RST;
        end
        if (err_set_valid) begin
            err_nxt = err_nxt | (err_set_bits & ERR_IMPL_MASK);
        end
    end

    // Parameter register storage
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            feat_r <= BYTE_RST;
            cnt_r <= COUNT_RST;
            sec_r <= BYTE_RST;
            cyl_lo_r <= BYTE_RST;
            cyl_hi_r <= BYTE_RST;
            dh_r <= DH_FIXED_ONES;
            ctl_r <= BYTE_RST;
            cmd_r <= BYTE_RST;
            cmd_go_r <= 1'b0;
            err_r <= BYTE_RST;
        end else begin
            feat_r <= feat_nxt;
            cnt_r <= cnt_nxt;
            sec_r <= sec_nxt;
            cyl_lo_r <= cyl_lo_nxt;
            cyl_hi_r <= cyl_hi_nxt;
            dh_r <= dh_nxt;
            ctl_r <= ctl_nxt;
            cmd_r <= cmd_nxt;
            cmd_go_r <= cmd_go_nxt;
            err_r <= err_nxt;
        end
    end

    // ----------------------------------------
    // Decoded command parameters
    // ----------------------------------------
    assign cmd_valid = cmd_go_r;
    assign cmd_code = cmd_r;
    assign feature_byte = feat_r;
    assign xfer_sectors = {(cnt_r == BYTE_RST), cnt_r};
    assign lba_mode = dh_r[DH_BIT_LBA];
    assign head_field = dh_r[3:0];
    assign lba_addr = lba_mode ? {head_field, cyl_hi_r, cyl_lo_r, sec_r} : 28'h0000000;
    assign cylinder = {cyl_hi_r, cyl_lo_r};
    assign start_sec = sec_r;
    assign drive_select_bit = dh_r[DH_BIT_DRIVE];
    assign drive_match = (drive_select_bit == card_id);
    assign soft_reset = ctl_r[CTL_BIT_SRST];
    assign irq_disable = ctl_r[CTL_BIT_NIEN];

    // ----------------------------------------
    // Sector data buffers
    // ----------------------------------------
    logic wf_valid, wf_ready, rf_valid, rf_ready;
    logic [DATA_W-1:0] wf_data, rf_data;
    logic wb_hi_r, wb_hi_nxt, rb_hi_r, rb_hi_nxt;
    logic [7:0] wb_low_r, wb_low_nxt;
    logic rf_pop;

    // Bytes pair low first; a word is pushed on the high byte
    always_comb begin
        wb_hi_nxt = wb_hi_r;
        wb_low_nxt = wb_low_r;
        rb_hi_nxt = rb_hi_r;
        wf_valid = 1'b0;
        wf_data = host_din;
        rf_pop = 1'b0;
        if (data_hit_wr) begin
            if (word_mode) begin
                wf_valid = 1'b1;
            end else if (!wb_hi_r) begin
                wb_low_nxt = host_din[7:0];
                wb_hi_nxt = 1'b1;
            end else begin
                wf_data = {host_din[7:0], wb_low_r};
                wf_valid = 1'b1;
                wb_hi_nxt = 1'b0;
            end
        end
        if (data_hit_rd) begin
            if (word_mode || rb_hi_r) begin
                rf_pop = rf_valid;
                rb_hi_nxt = 1'b0;
            end else begin
                rb_hi_nxt = 1'b1;
            end
        end
        // A new command restarts byte pairing
        if (cmd_take) begin
            wb_hi_nxt = 1'b0;
            rb_hi_nxt = 1'b0;
        end
    end

    // Byte pairing state
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wb_hi_r <= 1'b0;
            wb_low_r <= BYTE_RST;
            rb_hi_r <= 1'b0;
        end else begin
            wb_hi_r <= wb_hi_nxt;
            wb_low_r <= wb_low_nxt;
            rb_hi_r <= rb_hi_nxt;
        end
    end

    // Host to card; a full buffer drops the word, so the host watches wr_space
    sector_fifo #(.W(DATA_W), .DEPTH(DEPTH)) host_to_card (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_data(wf_data),
        .in_valid(wf_valid),
        .in_ready(wf_ready),
        .out_data(wdata),
        .out_valid(wvalid),
        .out_ready(wready)
    );

    // Card to host; card stalls on rready_in when the host lags
    sector_fifo #(.W(DATA_W), .DEPTH(DEPTH)) card_to_host (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_data(rdata_in),
        .in_valid(rvalid_in),
        .in_ready(rready_in),
        .out_data(rf_data),
        .out_valid(rf_valid),
        .out_ready(rf_ready)
    );

    assign rf_ready = rf_pop;
    assign wr_space = wf_ready;
    assign rd_avail = rf_valid;

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic [7:0] status_view, drv_addr_view;

    // While busy the other status bits mean nothing, so they read zero
    assign status_view = busy_flag ? STAT_BUSY_ONLY : {1'b0, status_low};
    assign drv_addr_view = DRV_ADDR_IDLE | {2'b00, ~head_field, card_id, ~card_id};

    // Read value captured on the strobe's falling edge
    always_comb begin
        dout_nxt = dout_r;
        if (rd_go && sel_task) begin
            unique case (addr)
                OFS_DATA: begin
                    if (word_mode) begin
                        dout_nxt = rf_data;
                    end else if (rb_hi_r) begin
                        dout_nxt = {8'h00, rf_data[15:8]};
                    end else begin
                        dout_nxt = {8'h00, rf_data[7:0]};
                    end
                end
                OFS_ERR_FEAT: dout_nxt = {8'h00, err_r & ERR_IMPL_MASK};
                OFS_COUNT: dout_nxt = {8'h00, cnt_r};
                OFS_SECTOR: dout_nxt = {8'h00, sec_r};
                OFS_CYL_LO: dout_nxt = {8'h00, cyl_lo_r};
                OFS_CYL_HI: dout_nxt = {8'h00, cyl_hi_r};
                OFS_DRV_HEAD: dout_nxt = {8'h00, dh_r | DH_FIXED_ONES};
                OFS_STAT_CMD: dout_nxt = {8'h00, status_view};
                default: begin
                end
            endcase
        end else if (rd_go && sel_ctl) begin
            if (addr == OFS_ALT_CTL) begin
                dout_nxt = {8'h00, status_view};
            end else begin
                dout_nxt = {8'h00, drv_addr_view};
            end
        end
    end

    // Read data register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dout_r <= '0;
        end else begin
            dout_r <= dout_nxt;
        end
    end

    assign host_dout = dout_r;
    assign host_doe = !rd_n && (sel_task || sel_ctl);
endmodule

// ===== src/ide_task_pkg.sv
// Constants shared by the task-file register block and its data buffer.
package ide_task_pkg;

    // ----------------------------------------
    // Task-file and control-block offsets (A2..A0)
    // ----------------------------------------
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_ERR_FEAT = 3'h1;
    localparam logic [2:0] OFS_COUNT = 3'h2;
    localparam logic [2:0] OFS_SECTOR = 3'h3;
    localparam logic [2:0] OFS_CYL_LO = 3'h4;
    localparam logic [2:0] OFS_CYL_HI = 3'h5;
    localparam logic [2:0] OFS_DRV_HEAD = 3'h6;
    localparam logic [2:0] OFS_STAT_CMD = 3'h7;
    localparam logic [2:0] OFS_ALT_CTL = 3'h6;
    localparam logic [2:0] OFS_DRV_ADDR = 3'h7;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int ERR_BIT_BAD_BLOCK = 7;
    localparam int ERR_BIT_UNCORRECTABLE = 6;
    localparam int ERR_BIT_SECTOR_MISSING = 4;
    localparam int ERR_BIT_ABORTED = 2;
    localparam int ERR_BIT_GENERAL = 0;
    localparam logic [7:0] ERR_IMPL_MASK = 8'hd5;
    localparam int DH_BIT_LBA = 6;
    localparam int DH_BIT_DRIVE = 4;
    localparam logic [7:0] DH_FIXED_ONES = 8'ha0;
    localparam int STAT_BIT_BUSY = 7;
    localparam logic [7:0] STAT_BUSY_ONLY = 8'h80;
    localparam int CTL_BIT_SRST = 2;
    localparam int CTL_BIT_NIEN = 1;
    localparam logic [7:0] COUNT_RST = 8'h01;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] DRV_ADDR_IDLE = 8'h40;

    // ----------------------------------------
    // Data path sizing
    // ----------------------------------------
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;

endpackage

// ===== dv/ide_task_regs_assertions.sv
// Port-level checks for the task-file register block.
`timescale 1ns/1ps
module ide_task_regs_checker
    import ide_task_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Sync reset
    input wire logic cs1_n, // Task select
    input wire logic cs2_n, // Control select
    input wire logic [2:0] addr, // Offset
    input wire logic rd_n, // Read strobe
    input wire logic wr_n, // Write strobe
    input wire logic word_mode, // Word access
    input wire logic [DATA_W-1:0] host_din, // Write data
    input wire logic host_doe, // Bus drive
    input wire logic wr_space, // Buffer room
    input wire logic card_id, // Our drive
    input wire logic busy_flag, // Busy
    input wire logic cnt_upd_valid, // Count update
    input wire logic [7:0] cnt_upd_value, // Remaining
    input wire logic cmd_valid, // Command pulse
    input wire logic [7:0] cmd_code, // Command
    input wire logic [8:0] xfer_sectors, // Count
    input wire logic lba_mode, // Linear mode
    input wire logic [27:0] lba_addr, // Block address
    input wire logic [15:0] cylinder, // Cylinder
    input wire logic [3:0] head_field, // Head
    input wire logic [7:0] start_sec, // Sector
    input wire logic drive_select_bit, // Drive bit
    input wire logic drive_match // Drive is us
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Decoded selects; both low at once is never driven
    logic tf_sel;
    logic cb_sel;
    assign tf_sel = !cs1_n && cs2_n;
    assign cb_sel = cs1_n && !cs2_n;
    a_count_reset: assert property ($rose(reset_n) |-> xfer_sectors == 9'h001)
        else $error("count not 01h after reset");
    a_count_remain: assert property (cnt_upd_valid && !$fell(wr_n) |=> xfer_sectors[7:0] == $past(cnt_upd_value))
        else $error("count update lost");
    a_count_write: assert property ($fell(wr_n) && tf_sel && addr == 3'h2 && !word_mode |=>
        xfer_sectors == ($past(host_din[7:0]) == 8'h00 ? 9'h100 : {1'b0, $past(host_din[7:0])}))
        else $error("count write not taken");
    a_lba_layout: assert property (lba_mode |-> lba_addr == {head_field, cylinder, start_sec})
        else $error("linear address layout wrong");
    a_chs_zero: assert property (!lba_mode |-> lba_addr == 28'h0)
        else $error("linear address in chs mode");
    a_drive_match: assert property (drive_match == (drive_select_bit == card_id))
        else $error("drive match wrong");
    a_cmd_taken: assert property ($fell(wr_n) && tf_sel && addr == 3'h7 && !busy_flag && drive_match
        |=> cmd_valid && cmd_code == $past(host_din[7:0]))
        else $error("command not issued");
    a_cmd_refused: assert property ($fell(wr_n) && tf_sel && addr == 3'h7 && busy_flag |=> !cmd_valid)
        else $error("command taken while busy");
    a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse too long");
    a_doe_decode: assert property (cs1_n != cs2_n |->
        host_doe == (!rd_n && (tf_sel || (cb_sel && addr[2:1] == 2'b11))))
        else $error("bus drive decode wrong");
    c_cmd: cover property (cmd_valid);
    c_lba: cover property (lba_mode);
    c_full: cover property (!wr_space);
    c_256: cover property (xfer_sectors == 9'h100);
endmodule
bind ide_task_regs ide_task_regs_checker u_chk (.*);

// ===== dv/card_side_model.sv
// Card-side model: sector word sink with stall, numbered word source.
`timescale 1ns/1ps
module card_side_model (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Sync reset
    input wire logic [15:0] wdata, // Word from buffer
    input wire logic wvalid, // Word offered
    output logic wready, // Sink takes word
    output logic [15:0] rdata_in, // Word to buffer
    output logic rvalid_in, // Word offered
    input wire logic rready_in, // Buffer room
    input wire logic stall, // Hold off sink
    input wire logic src_on // Source enable
);
    logic [15:0] got [$];
    logic [15:0] seq_r;
    // Sink and source handshakes; idle data is inverted so stale words never look valid
    assign wready = !stall;
    assign rvalid_in = src_on;
    assign rdata_in = src_on ? seq_r : ~seq_r;
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            seq_r <= 16'hc300;
        end else begin
            if (wvalid && wready) got.push_back(wdata);
            if (rvalid_in && rready_in) seq_r <= seq_r + 16'h0001;
        end
    end
endmodule

// ===== dv/ide_task_regs_tb.sv
// Self-checking bench for the task-file register block.
`timescale 1ns/1ps
module ide_task_regs_tb;
    import ide_task_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, cs1_n = 1'b1, cs2_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic [2:0] addr = 3'h0;
    logic word_mode = 1'b0, busy_flag = 1'b0, err_set_valid = 1'b0, cnt_upd_valid = 1'b0;
    logic stall = 1'b0, src_on = 1'b0, oe;
    logic [15:0] host_din = 16'h0000, host_dout, q, wdata, rdata_in;
    logic [6:0] status_low = 7'h55;
    logic [7:0] err_set_bits = 8'h00, cnt_upd_value = 8'h00, cmd_code, feature_byte, start_sec;
    logic host_doe, wr_space, rd_avail, cmd_valid, lba_mode, drive_select_bit, drive_match;
    logic soft_reset, irq_disable, wvalid, wready, rvalid_in, rready_in;
    logic [8:0] xfer_sectors;
    logic [27:0] lba_addr;
    logic [15:0] cylinder;
    logic [3:0] head_field;
    int error_cnt = 0, n_checks = 0, i;
    always #2.5 ref_clk = ~ref_clk;
    ide_task_regs #(.DEPTH(8)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cs1_n(cs1_n), .cs2_n(cs2_n),
        .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .word_mode(word_mode), .host_din(host_din),
        .host_dout(host_dout), .host_doe(host_doe), .wr_space(wr_space), .rd_avail(rd_avail),
        .card_id(1'b0), .busy_flag(busy_flag), .status_low(status_low), .err_set_valid(err_set_valid),
        .err_set_bits(err_set_bits), .cnt_upd_valid(cnt_upd_valid), .cnt_upd_value(cnt_upd_value),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .feature_byte(feature_byte), .xfer_sectors(xfer_sectors),
        .lba_mode(lba_mode), .lba_addr(lba_addr), .cylinder(cylinder), .head_field(head_field),
        .start_sec(start_sec), .drive_select_bit(drive_select_bit), .drive_match(drive_match),
        .soft_reset(soft_reset), .irq_disable(irq_disable), .wdata(wdata), .wvalid(wvalid), .wready(wready),
        .rdata_in(rdata_in), .rvalid_in(rvalid_in), .rready_in(rready_in));
    card_side_model u_card (.ref_clk(ref_clk), .reset_n(reset_n), .wdata(wdata), .wvalid(wvalid),
        .wready(wready), .rdata_in(rdata_in), .rvalid_in(rvalid_in), .rready_in(rready_in),
        .stall(stall), .src_on(src_on));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One strobe cycle low, one high; entered just after a rising edge
    task automatic acc(input logic c1, input logic c2, input logic [2:0] a, input logic wm, input logic wr,
        input logic [15:0] d);
        cs1_n = c1;
        cs2_n = c2;
        addr = a;
        word_mode = wm;
        host_din = d;
        if (wr) wr_n = 1'b0;
        else rd_n = 1'b0;
        #1 oe = host_doe;
        @(posedge ref_clk);
        #1 q = host_dout;
        wr_n = 1'b1;
        rd_n = 1'b1;
        cs1_n = 1'b1;
        cs2_n = 1'b1;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic tw(input logic [2:0] a, input logic [7:0] d);
        acc(1'b0, 1'b1, a, 1'b0, 1'b1, {8'h00, d});
    endtask
    task automatic tr(input logic [2:0] a, input logic [7:0] e);
        acc(1'b0, 1'b1, a, 1'b0, 1'b0, 16'h0000);
        chk(q[7:0], e);
    endtask
    task automatic pulse_err(input logic [7:0] b);
        err_set_bits = b;
        err_set_valid = 1'b1;
        @(posedge ref_clk);
        #1 err_set_valid = 1'b0;
    endtask
    task automatic done(input string s);
        $display("%0s finished", s);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog sized well above the roughly 160 cycles the tests need
    initial begin
        #50000;
        error_cnt++;
        tally_and_finish();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        chk(xfer_sectors, 32'h1);
        tr(OFS_COUNT, 8'h01);
        tr(OFS_DRV_HEAD, 8'ha0);
        tr(OFS_ERR_FEAT, 8'h00);
        done("reset");
        // Host loads parameters while busy_flag is held low
        tw(OFS_SECTOR, 8'h3c);
        tw(OFS_CYL_LO, 8'h5a);
        tw(OFS_CYL_HI, 8'h96);
        tw(OFS_DRV_HEAD, 8'h0b);
        tr(OFS_DRV_HEAD, 8'hab);
        chk({lba_mode, lba_addr}, 32'h0);
        chk({cylinder, start_sec, head_field}, 32'h965a3cb);
        tw(OFS_DRV_HEAD, 8'h4b);
        chk({lba_mode, lba_addr}, 32'h1b965a3c);
        chk({drive_select_bit, drive_match}, 32'h1);
        tr(OFS_SECTOR, 8'h3c);
        tr(OFS_CYL_HI, 8'h96);
        tw(OFS_COUNT, 8'h00);
        chk(xfer_sectors, 32'h100);
        tw(OFS_COUNT, 8'hff);
        tr(OFS_COUNT, 8'hff);
        cnt_upd_value = 8'h07;
        cnt_upd_valid = 1'b1;
        @(posedge ref_clk);
        #1 cnt_upd_valid = 1'b0;
        chk(xfer_sectors, 32'h7);
        done("parameters");
        // Each error bit alone, cleared by a command in between
        for (i = 0; i < 8; i++) begin
            pulse_err(8'h01 << i);
            tr(OFS_ERR_FEAT, (8'h01 << i) & 8'hd5);
            tw(OFS_STAT_CMD, 8'h20);
        end
        tr(OFS_ERR_FEAT, 8'h00);
        chk(cmd_code, 32'h20);
        pulse_err(8'h80);
        tw(OFS_ERR_FEAT, 8'h77);
        chk(feature_byte, 32'h77);
        tr(OFS_ERR_FEAT, 8'h80);
        busy_flag = 1'b1;
        tr(OFS_STAT_CMD, 8'h80);
        tw(OFS_STAT_CMD, 8'h30);
        busy_flag = 1'b0;
        tr(OFS_ERR_FEAT, 8'h80);
        tr(OFS_STAT_CMD, 8'h55);
        done("errors");
        // Control block: device control, alt status, drive address, unmapped
        acc(1'b1, 1'b0, OFS_ALT_CTL, 1'b0, 1'b1, 16'h0006);
        chk({soft_reset, irq_disable}, 32'h3);
        acc(1'b1, 1'b0, OFS_ALT_CTL, 1'b0, 1'b0, 16'h0000);
        chk({oe, q[7:0]}, 32'h155);
        acc(1'b1, 1'b0, OFS_DRV_ADDR, 1'b0, 1'b0, 16'h0000);
        chk(q[7:0], 32'h51);
        acc(1'b1, 1'b0, 3'h0, 1'b0, 1'b0, 16'h0000);
        chk(oe, 32'h0);
        acc(1'b1, 1'b0, OFS_ALT_CTL, 1'b0, 1'b1, 16'h0000);
        done("control");
        // Write buffer filled against a stalled sink, one extra word dropped
        stall = 1'b1;
        for (i = 0; i < 9; i++) acc(1'b0, 1'b1, OFS_DATA, 1'b1, 1'b1, 16'ha0 + i);
        chk(wr_space, 32'h0);
        stall = 1'b0;
        tw(OFS_DATA, 8'h34);
        tw(OFS_DATA, 8'h12);
        repeat (12) @(posedge ref_clk);
        #1 chk(u_card.got.size(), 32'h9);
        for (i = 0; i < 8; i++) chk(u_card.got[i], 16'ha0 + i);
        chk(u_card.got[8], 32'h1234);
        chk(wr_space, 32'h1);
        // Read buffer filled by the card, then drained by seven word reads and one byte pair
        src_on = 1'b1;
        repeat (12) @(posedge ref_clk);
        #1 src_on = 1'b0;
        chk({rd_avail, rready_in}, 32'h2);
        for (i = 0; i < 7; i++) begin
            acc(1'b0, 1'b1, OFS_DATA, 1'b1, 1'b0, 16'h0000);
            chk(q, 16'hc300 + i);
        end
        tr(OFS_DATA, 8'h07);
        tr(OFS_DATA, 8'hc3);
        chk(rd_avail, 32'h0);
        done("data");
        tally_and_finish();
    end
endmodule
